//--- hw/skip_branch_unit.sv
`timescale 1ns/1ns
// Summary of operation
// RULE_01: Register bit set skips next instruction.
// RULE_02: I/O bit clear skips next instruction.
// RULE_03: I/O bit set skips next instruction.
// RULE_04: Flag set branches to pc plus k plus one.
// RULE_05: Flag clear branches; flags never modified.
// RULE_06: Carry clear branch taken when carry zero.
// RULE_07: Same-or-higher branch uses carry-clear condition.
// RULE_08: Branch offset is signed two's complement.
module skip_branch_unit (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire skip_branch_pkg::req_t req,
    output logic ready,
    output logic done,
    output skip_branch_pkg::resp_t resp,
    output logic flag_write_en
);

    typedef enum logic {idle_s, busy_s} state_t;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic sel_bit(
        input logic [skip_branch_pkg::DATA_W-1:0] data,
        input logic [skip_branch_pkg::SEL_W-1:0] idx
    );
        sel_bit = data[idx];
    endfunction

    logic reg_bit;
    logic io_bit;
    logic flag_bit;
    logic carry_bit;
    logic skip_c;
    logic taken_c;
    logic accept;
    logic [skip_branch_pkg::PC_W-1:0] branch_target;
    logic [skip_branch_pkg::PC_W-1:0] target_c;
    logic [skip_branch_pkg::CNT_W-1:0] cycles_c;

    assign reg_bit = sel_bit(req.reg_val, req.bit_sel);
    assign io_bit = sel_bit(req.io_val, req.bit_sel);
    assign flag_bit = sel_bit(req.flag_register, req.bit_sel);
    assign carry_bit = sel_bit(req.flag_register, skip_branch_pkg::CARRY_SEL);

    pc_offset_adder #(
        .PC_W(skip_branch_pkg::PC_W),
        .OFS_W(skip_branch_pkg::OFS_W)
    ) u_adder (
        .base(req.pc),
        .offset(req.offset),
        .target(branch_target)
    );

    // ----------------------------------------------------------------
    // Condition and target selection
    // ----------------------------------------------------------------
    always_comb begin
        skip_c = 1'b0;
        taken_c = 1'b0;
        case (req.op)
            skip_branch_pkg::op_skip_if_reg_bit_set: begin
                skip_c = reg_bit; // RULE_01
            end
            skip_branch_pkg::op_skip_if_io_bit_clear: begin
                skip_c = ~io_bit; // RULE_02
            end
            skip_branch_pkg::op_skip_if_io_bit_set: begin
                skip_c = io_bit; // RULE_03
            end
            skip_branch_pkg::op_branch_if_flag_set: begin
                taken_c = flag_bit; // RULE_04
            end
            skip_branch_pkg::op_branch_if_flag_clear: begin
                taken_c = ~flag_bit; // RULE_05
            end
            skip_branch_pkg::op_branch_if_carry_clear: begin
                taken_c = ~carry_bit; // RULE_06
            end
            skip_branch_pkg::op_branch_if_same_or_higher: begin
                taken_c = ~carry_bit; // RULE_07
            end
            default: begin
                skip_c = 1'b0;
            end
        endcase
    end

    // Skipping a two-word instruction costs one more cycle than a
    // one-word one, since the fetch must step over both words.
    always_comb begin
        target_c = req.pc + skip_branch_pkg::STEP_SEQ;
        cycles_c = skip_branch_pkg::CYC_SEQ;
        if (taken_c) begin
            target_c = branch_target; // RULE_04
            cycles_c = skip_branch_pkg::CYC_TAKEN;
        end else if (skip_c && req.next_is_two_word) begin
            target_c = req.pc + skip_branch_pkg::STEP_SKIP_TWO; // RULE_01
            cycles_c = skip_branch_pkg::CYC_SKIP_TWO;
        end else if (skip_c) begin
            target_c = req.pc + skip_branch_pkg::STEP_SKIP_ONE; // RULE_01
            cycles_c = skip_branch_pkg::CYC_SKIP_ONE;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    state_t state_q;
    state_t state_d;
    logic [skip_branch_pkg::CNT_W-1:0] cnt_q;
    logic [skip_branch_pkg::CNT_W-1:0] cnt_d;
    skip_branch_pkg::resp_t resp_q;
    skip_branch_pkg::resp_t resp_d;

    assign ready = (state_q == idle_s);
    assign accept = start && ready;
    assign done = (state_q == busy_s) && (cnt_q == skip_branch_pkg::CNT_LAST);
    assign resp = resp_q;
    // The unit never writes the flag register.
    assign flag_write_en = 1'b0; // RULE_05

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        resp_d = resp_q;
        case (state_q)
            idle_s: begin
                if (accept) begin
                    state_d = busy_s;
                    cnt_d = cycles_c;
                    resp_d.pc_next = target_c;
                    resp_d.taken = taken_c;
                    resp_d.skipped = skip_c;
                end
            end
            busy_s: begin
                cnt_d = cnt_q - skip_branch_pkg::CNT_LAST;
                if (cnt_q == skip_branch_pkg::CNT_LAST) begin
                    state_d = idle_s;
                    cnt_d = skip_branch_pkg::CNT_ZERO;
                end
            end
            default: begin
                state_d = idle_s;
                cnt_d = skip_branch_pkg::CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= idle_s;
            cnt_q <= skip_branch_pkg::CNT_ZERO;
            resp_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            resp_q <= resp_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [skip_branch_pkg::PC_W-1:0] ofs_ext;

    assign ofs_ext = {{(skip_branch_pkg::PC_W-skip_branch_pkg::OFS_W){
        req.offset[skip_branch_pkg::OFS_W-1]}}, req.offset};

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    reg_skip_one_a: assert property ( // RULE_01
        accept && req.op == skip_branch_pkg::op_skip_if_reg_bit_set && reg_bit
            && !req.next_is_two_word
        |=> resp.pc_next == $past(req.pc) + skip_branch_pkg::STEP_SKIP_ONE && !done
            ##1 done)
        else $error("register bit skip target or timing wrong");

    io_clear_two_a: assert property ( // RULE_02
        accept && req.op == skip_branch_pkg::op_skip_if_io_bit_clear && !io_bit
            && req.next_is_two_word
        |=> resp.pc_next == $past(req.pc) + skip_branch_pkg::STEP_SKIP_TWO
            ##0 !done[*2] ##1 done)
        else $error("io clear skip over two words wrong");

    io_set_seq_a: assert property ( // RULE_03
        accept && req.op == skip_branch_pkg::op_skip_if_io_bit_set
        |=> resp.skipped == $past(io_bit) && (done == !resp.skipped))
        else $error("io set skip decision wrong");

    flag_set_a: assert property ( // RULE_04
        accept && req.op == skip_branch_pkg::op_branch_if_flag_set && flag_bit
        |=> resp.pc_next == $past(req.pc) + $past(ofs_ext) + skip_branch_pkg::STEP_SEQ
            && resp.taken ##1 done)
        else $error("flag set branch target wrong");

    flag_clear_a: assert property ( // RULE_05
        accept && req.op == skip_branch_pkg::op_branch_if_flag_clear
        |=> resp.taken == !$past(flag_bit) && !flag_write_en)
        else $error("flag clear branch decision wrong");

    carry_clear_a: assert property ( // RULE_06
        accept && req.op == skip_branch_pkg::op_branch_if_carry_clear
        |=> resp.taken == !$past(req.flag_register[skip_branch_pkg::CARRY_SEL]))
        else $error("carry clear branch decision wrong");

    same_higher_a: assert property ( // RULE_07
        accept && req.op == skip_branch_pkg::op_branch_if_same_or_higher
        |=> resp.taken == !$past(req.flag_register[skip_branch_pkg::CARRY_SEL])
            && resp.pc_next == ($past(carry_bit) ? $past(req.pc) + skip_branch_pkg::STEP_SEQ
                : $past(req.pc) + $past(ofs_ext) + skip_branch_pkg::STEP_SEQ))
        else $error("same or higher branch wrong");

    backward_branch_a: assert property ( // RULE_08
        accept && taken_c && req.offset[skip_branch_pkg::OFS_W-1]
        |=> $past(req.pc) - resp.pc_next == ~$past(ofs_ext))
        else $error("backward branch distance wrong");

endmodule // skip_branch_unit

//--- inc/skip_branch_pkg.sv
package skip_branch_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PC_W = 12;
    localparam int OFS_W = 7;
    localparam int SEL_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 2;

    // ----------------------------------------------------------------
    // Field positions, steps and cycle counts
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] CARRY_SEL = 3'h0;
    localparam logic [PC_W-1:0] STEP_SEQ = 12'h001;
    localparam logic [PC_W-1:0] STEP_SKIP_ONE = 12'h002;
    localparam logic [PC_W-1:0] STEP_SKIP_TWO = 12'h003;
    localparam logic [CNT_W-1:0] CYC_SEQ = 2'h1;
    localparam logic [CNT_W-1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [CNT_W-1:0] CYC_SKIP_TWO = 2'h3;
    localparam logic [CNT_W-1:0] CYC_TAKEN = 2'h2;
    localparam logic [CNT_W-1:0] CNT_LAST = 2'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        op_skip_if_reg_bit_set,
        op_skip_if_io_bit_clear,
        op_skip_if_io_bit_set,
        op_branch_if_flag_set,
        op_branch_if_flag_clear,
        op_branch_if_carry_clear,
        op_branch_if_same_or_higher,
        op_none
    } op_t;

    typedef struct packed {
        op_t op;
        logic [SEL_W-1:0] bit_sel;
        logic [OFS_W-1:0] offset;
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] reg_val;
        logic [DATA_W-1:0] io_val;
        logic [DATA_W-1:0] flag_register;
        logic next_is_two_word;
    } req_t;

    typedef struct packed {
        logic [PC_W-1:0] pc_next;
        logic taken;
        logic skipped;
    } resp_t;

endpackage

//--- hw/pc_offset_adder.sv
`timescale 1ns/1ns
module pc_offset_adder #(
    parameter int PC_W = skip_branch_pkg::PC_W,
    parameter int OFS_W = skip_branch_pkg::OFS_W
) (
    input wire logic [PC_W-1:0] base,
    input wire logic [OFS_W-1:0] offset,
    output logic [PC_W-1:0] target
);

    // ----------------------------------------------------------------
    // Relative target
    // ----------------------------------------------------------------
    // The offset is sign-extended so a branch may reach backward; the
    // sum wraps in the program space like the counter itself.
    logic [PC_W-1:0] offset_ext;

    assign offset_ext = {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset}; // RULE_08
    assign target = base + offset_ext + skip_branch_pkg::STEP_SEQ; // RULE_08

endmodule // pc_offset_adder

//--- testbench/skip_branch_unit_tb.sv
`timescale 1ns/1ns
module skip_branch_unit_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    skip_branch_pkg::req_t req = '0;
    logic ready;
    logic done;
    skip_branch_pkg::resp_t resp;
    logic flag_write_en;
    int num_errors = 0;
    int total_checks = 0;

    always #10 sys_clk = ~sys_clk;

    skip_branch_unit u_skip_branch_unit (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(start),
        .req(req),
        .ready(ready),
        .done(done),
        .resp(resp),
        .flag_write_en(flag_write_en)
    );

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_pc(string what, logic [11:0] exp, logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(string what, logic exp, logic got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    // ----------------------------------------------------------------
    // One request; outc is 0 for sequential, 1 for a skip, 2 for a taken branch.
    // ----------------------------------------------------------------
    task automatic run_op(skip_branch_pkg::op_t op, logic [2:0] sel, logic [6:0] k,
                          logic [11:0] pc, logic [7:0] rv, logic [7:0] iv,
                          logic [7:0] fl, logic two, int outc);
        int n;
        logic [11:0] exp_pc;
        n = 0;
        while (ready !== 1'b1) begin
            n++;
            if (n > 8) begin
                num_errors++;
                give_verdict();
            end
            @(posedge sys_clk);
            #1;
        end
        start = 1'b1;
        req = '{op, sel, k, pc, rv, iv, fl, two};
        @(posedge sys_clk);
        #1;
        start = 1'b0;
        n = 1;
        while (done !== 1'b1) begin
            check_bit("ready while busy", 1'b0, ready);
            check_bit("flag write", 1'b0, flag_write_en);
            n++;
            if (n > 8) begin
                num_errors++;
                give_verdict();
            end
            @(posedge sys_clk);
            #1;
        end
        exp_pc = (outc == 2) ? pc + {{5{k[6]}}, k} + 12'h001 :
                 (outc == 1) ? pc + (two ? 12'h003 : 12'h002) : pc + 12'h001;
        check_pc("cycles to done", (outc == 1 && two) ? 12'h003 : (outc > 0) ? 12'h002 :
                 12'h001, 12'(n));
        check_pc("next pc", exp_pc, resp.pc_next);
        check_bit("taken", outc == 2, resp.taken);
        check_bit("skipped", outc == 1, resp.skipped);
        check_bit("flag write", 1'b0, flag_write_en);
        @(posedge sys_clk);
        #1;
        check_bit("done pulse length", 1'b0, done);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_skips();
        run_op(skip_branch_pkg::op_skip_if_reg_bit_set, 3'h7, 7'h00, 12'h100, 8'h80, 8'h00,
               8'h00, 1'b0, 1);
        run_op(skip_branch_pkg::op_skip_if_reg_bit_set, 3'h7, 7'h00, 12'hFFE, 8'h80, 8'h00,
               8'h00, 1'b1, 1);
        run_op(skip_branch_pkg::op_skip_if_reg_bit_set, 3'h7, 7'h00, 12'h100, 8'h7F, 8'hFF,
               8'hFF, 1'b0, 0);
        run_op(skip_branch_pkg::op_skip_if_io_bit_clear, 3'h3, 7'h00, 12'h120, 8'hFF, 8'hF7,
               8'h00, 1'b1, 1);
        run_op(skip_branch_pkg::op_skip_if_io_bit_clear, 3'h3, 7'h00, 12'h120, 8'h00, 8'h08,
               8'h00, 1'b0, 0);
        run_op(skip_branch_pkg::op_skip_if_io_bit_set, 3'h3, 7'h00, 12'h140, 8'h00, 8'h08,
               8'h00, 1'b0, 1);
        run_op(skip_branch_pkg::op_skip_if_io_bit_set, 3'h3, 7'h00, 12'h140, 8'hFF, 8'hF7,
               8'h00, 1'b1, 0);
        $display("test skips finished");
    endtask

    task automatic t_flags();
        logic [7:0] fl;
        for (int i = 0; i < 8; i++) begin
            fl = 8'h01 << i;
            run_op(skip_branch_pkg::op_branch_if_flag_set, 3'(i), 7'(i * 9), 12'h200, 8'h00,
                   8'h00, fl, 1'b0, 2);
            run_op(skip_branch_pkg::op_branch_if_flag_set, 3'(i), 7'(i * 9), 12'h200, 8'h00,
                   8'h00, ~fl, 1'b0, 0);
            run_op(skip_branch_pkg::op_branch_if_flag_clear, 3'(i), 7'(i * 5), 12'h300, 8'h00,
                   8'h00, ~fl, 1'b1, 2);
            run_op(skip_branch_pkg::op_branch_if_flag_clear, 3'(i), 7'(i * 5), 12'h300, 8'h00,
                   8'h00, fl, 1'b0, 0);
        end
        $display("test flag branches finished");
    endtask

    task automatic t_carry();
        run_op(skip_branch_pkg::op_branch_if_carry_clear, 3'h5, 7'h12, 12'h400, 8'h00, 8'h00,
               8'hFE, 1'b0, 2);
        run_op(skip_branch_pkg::op_branch_if_carry_clear, 3'h5, 7'h12, 12'h400, 8'h00, 8'h00,
               8'h01, 1'b0, 0);
        run_op(skip_branch_pkg::op_branch_if_same_or_higher, 3'h6, 7'h21, 12'h410, 8'h00,
               8'h00, 8'hFE, 1'b0, 2);
        run_op(skip_branch_pkg::op_branch_if_same_or_higher, 3'h6, 7'h21, 12'h410, 8'h00,
               8'h00, 8'h01, 1'b0, 0);
        run_op(skip_branch_pkg::op_none, 3'h0, 7'h21, 12'h420, 8'hFF, 8'h00,
               8'h00, 1'b1, 0);
        $display("test carry branches finished");
    endtask

    task automatic t_signed();
        run_op(skip_branch_pkg::op_branch_if_flag_set, 3'h0, 7'h40, 12'h010, 8'h00, 8'h00,
               8'h01, 1'b0, 2);
        run_op(skip_branch_pkg::op_branch_if_flag_set, 3'h0, 7'h3F, 12'hFFF, 8'h00, 8'h00,
               8'h01, 1'b0, 2);
        run_op(skip_branch_pkg::op_branch_if_flag_clear, 3'h1, 7'h7F, 12'h000, 8'h00, 8'h00,
               8'h00, 1'b0, 2);
        $display("test signed offsets finished");
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_skips();
        t_flags();
        t_carry();
        t_signed();
        give_verdict();
    end
endmodule // skip_branch_unit_tb
